/* dasc_channel.sv */
// One asynchronous serial channel with host registers, modem lines and interrupt
`timescale 1ns/10ps
module dasc_channel (
   input wire logic clock,
   input wire logic srst,
   input wire logic sel,
   input wire dasc_pkg::dasc_host_req_t req,
   output logic [7:0] readData,
   output logic readValid,
   input wire logic serialRxIn,
   input wire dasc_pkg::dasc_modem_in_t modemIn,
   output logic serialTxOut,
   output logic terminalReadyN,
   output logic sendRequestN,
   output logic chanIrqOut,
   output logic chanIrqOe
);
   logic [7:0] lineControlReg;
   logic [7:0] modemControlReg;
   logic [7:0] lineStatusReg;
   logic [3:0] irqEnable;
   logic [7:0] scratch;
   logic [15:0] divisor;
   logic [7:0] txHoldingReg;
   logic [7:0] rxBufferReg;
   logic [3:0] deltaFlags;
   logic txEmptyIrq;
   logic rxLineIrq;
   logic [15:0] baudCount;
   logic baudTick;
   logic [3:0] txPhase;
   logic [3:0] txBitIdx;
   logic [10:0] txShift;
   logic txBusy;
   logic [3:0] rxPhase;
   logic [3:0] rxBitIdx;
   logic [9:0] rxShift;
   logic rxBusy;
   logic [3:0] modemPrev;
   logic [2:0] next_iid;
   logic [7:0] next_read;
   logic wrEn;
   logic rdEn;
   logic divAccess;
   logic loopMode;
   logic rxLine;
   dasc_pkg::dasc_modem_in_t modemEff;
   logic [3:0] modemLevel;
   logic [3:0] dataBits;

   function automatic logic [3:0] word_bits(input logic [1:0] wls);
      word_bits = {2'b00, wls} + 4'h5;
   endfunction : word_bits

   function automatic logic char_parity(input logic [7:0] d, input logic [3:0] n,
                                        input logic [7:0] line_control_reg);
      logic p;
      p = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < n) p = p ^ d[i];
      end
      if (line_control_reg[dasc_pkg::LCR_STICK]) char_parity = ~line_control_reg[dasc_pkg::LCR_EVEN];
      else char_parity = p ^ ~line_control_reg[dasc_pkg::LCR_EVEN];
   endfunction : char_parity

   assign wrEn = sel && req.wr;
   assign rdEn = sel && req.rd;
   assign divAccess = lineControlReg[dasc_pkg::LCR_DIV_ACCESS];
   assign loopMode = modemControlReg[dasc_pkg::MCR_LOOP];
   assign dataBits = word_bits(lineControlReg[1:0]);
   // Loop mode feeds the transmitter back and the modem outputs to the inputs
   assign rxLine = loopMode ? txShift[0] | ~txBusy : serialRxIn;
   assign modemEff = loopMode ?
      {~modemControlReg[1], ~modemControlReg[0], ~modemControlReg[2], ~modemControlReg[3]}
      : modemIn;
   assign modemLevel = {~modemEff.carrierN, ~modemEff.ringInN, ~modemEff.setReadyN,
                        ~modemEff.sendClearN};

   // Baud enable: one pulse every divisor cycles, 16 per bit
   // A divisor of zero acts as one rather than stalling the line
   always_ff @(posedge clock) begin
      if (srst) begin
         baudCount <= 16'h0000;
         baudTick <= 1'b0;
      end else if (baudCount + 16'h0001 >= divisor) begin
         baudCount <= 16'h0000;
         baudTick <= 1'b1;
      end else begin
         baudCount <= baudCount + 16'h0001;
         baudTick <= 1'b0;
      end
   end

   // Host writes
   always_ff @(posedge clock) begin
      if (srst) begin
         lineControlReg <= 8'h00;
         modemControlReg <= dasc_pkg::MCR_RESET;
         irqEnable <= 4'h0;
         scratch <= 8'h00;
         divisor <= dasc_pkg::DIV_RESET;
         txHoldingReg <= 8'h00;
      end else if (wrEn) begin
         if (req.addr == dasc_pkg::OFS_DATA && divAccess) begin
            divisor[7:0] <= req.data;
         end else if (req.addr == dasc_pkg::OFS_IEN && divAccess) begin
            divisor[15:8] <= req.data;
         end else if (req.addr == dasc_pkg::OFS_DATA) begin
            txHoldingReg <= req.data;
         end else if (req.addr == dasc_pkg::OFS_IEN) begin
            irqEnable <= req.data[3:0];
         end else if (req.addr == dasc_pkg::OFS_LCR) begin
            lineControlReg <= req.data;
         end else if (req.addr == dasc_pkg::OFS_MCR) begin
            // Upper three bits have no function and always read as zero
            modemControlReg <= {3'b000, req.data[4:0]};
         end else if (req.addr == dasc_pkg::OFS_SCR) begin
            scratch <= req.data;
         end
      end
   end

   assign terminalReadyN = ~modemControlReg[dasc_pkg::MCR_TERM_READY];
   assign sendRequestN = ~modemControlReg[dasc_pkg::MCR_SEND_REQ];

   // Transmitter: start bit, data LSB first, parity, stop bits
   always_ff @(posedge clock) begin
      if (srst) begin
         txBusy <= 1'b0;
         txShift <= 11'h7FF;
         txPhase <= 4'h0;
         txBitIdx <= 4'h0;
      end else if (!txBusy) begin
         txShift <= 11'h7FF;
         if (!lineStatusReg[dasc_pkg::LSR_TX_HOLD_EMPTY] && baudTick) begin
            txBusy <= 1'b1;
            txPhase <= 4'h0;
            txBitIdx <= 4'h0;
            // Unused data bits are forced to mark so short words keep their stop bits
            txShift <= {2'b11, 8'(txHoldingReg | (8'hFF << dataBits)), 1'b0};
            if (lineControlReg[dasc_pkg::LCR_PAR_EN]) begin
               txShift[4'(dataBits) + 4'h1] <=
                  char_parity(txHoldingReg, dataBits, lineControlReg);
            end
         end
      end else if (baudTick) begin
         txPhase <= txPhase + 4'h1;
         if (txPhase == dasc_pkg::OVERSAMPLE) begin
            txShift <= {1'b1, txShift[10:1]};
            txBitIdx <= txBitIdx + 4'h1;
            // Frame length: start + data + parity + stop(s); 1.5 stops rounded to 2
            if (txBitIdx == dataBits + {3'b000, lineControlReg[dasc_pkg::LCR_PAR_EN]}
                + {3'b000, lineControlReg[dasc_pkg::LCR_STOP2]} + 4'h1) begin
               txBusy <= 1'b0;
            end
         end
      end
   end

   // Break forces space only while a frame is sent; loop and idle hold mark even with break set
   always_ff @(posedge clock) begin
      if (srst) begin
         serialTxOut <= 1'b1;
      end else if (loopMode || !txBusy) begin
         serialTxOut <= 1'b1;
      end else begin
         serialTxOut <= txShift[0] & ~lineControlReg[dasc_pkg::LCR_BREAK];
      end
   end

   // Receiver: majority-free mid-bit sampling at the 16x enable
   always_ff @(posedge clock) begin
      if (srst) begin
         rxBusy <= 1'b0;
         rxPhase <= 4'h0;
         rxBitIdx <= 4'h0;
         rxShift <= 10'h000;
      end else if (baudTick) begin
         if (!rxBusy) begin
            rxPhase <= 4'h0;
            rxBitIdx <= 4'h0;
            if (!rxLine) rxBusy <= 1'b1;
         end else begin
            rxPhase <= rxPhase + 4'h1;
            if (rxPhase == dasc_pkg::MID_SAMPLE) begin
               rxShift <= {rxLine, rxShift[9:1]};
               rxBitIdx <= rxBitIdx + 4'h1;
               if (rxBitIdx == 4'h0 && rxLine) rxBusy <= 1'b0;
               if (rxBitIdx == dataBits + {3'b000, lineControlReg[dasc_pkg::LCR_PAR_EN]} +
                   4'h1) begin
                  rxBusy <= 1'b0;
               end
            end
         end
      end
   end

   // Stop-bit strobe shared by the receive buffer and its flags
   logic stopSeen;
   assign stopSeen = baudTick && rxBusy && rxPhase == dasc_pkg::MID_SAMPLE &&
      rxBitIdx == dataBits + {3'b000, lineControlReg[dasc_pkg::LCR_PAR_EN]} + 4'h1;

   // Line status, receive buffer and line-error interrupt
   always_ff @(posedge clock) begin
      logic [9:0] frame;
      logic [7:0] dataOut;
      logic parErr;
      frame = 10'h000;
      dataOut = 8'h00;
      parErr = 1'b0;
      if (srst) begin
         lineStatusReg <= dasc_pkg::LSR_RESET;
         rxBufferReg <= 8'h00;
         rxLineIrq <= 1'b0;
      end else begin
         if (rdEn && !divAccess && req.addr == dasc_pkg::OFS_DATA) begin
            lineStatusReg[0] <= 1'b0;
         end
         if (rdEn && req.addr == dasc_pkg::OFS_LSR) begin
            lineStatusReg[4:1] <= 4'h0;
            rxLineIrq <= 1'b0;
         end
         if (wrEn && !divAccess && req.addr == dasc_pkg::OFS_DATA) begin
            lineStatusReg[dasc_pkg::LSR_TX_HOLD_EMPTY] <= 1'b0;
            lineStatusReg[dasc_pkg::LSR_TX_ALL_EMPTY] <= 1'b0;
         end else if (!txBusy && !lineStatusReg[dasc_pkg::LSR_TX_HOLD_EMPTY] && baudTick) begin
            lineStatusReg[dasc_pkg::LSR_TX_HOLD_EMPTY] <= 1'b1;
         end else if (!txBusy && lineStatusReg[dasc_pkg::LSR_TX_HOLD_EMPTY]) begin
            lineStatusReg[dasc_pkg::LSR_TX_ALL_EMPTY] <= 1'b1;
         end
         // Set beats a same-cycle read clear
         if (stopSeen) begin
            // Right-aligned without the start bit: data, then parity, then stop
            frame = {rxLine, rxShift[9:1]} >> (4'h9 - dataBits -
               {3'b000, lineControlReg[dasc_pkg::LCR_PAR_EN]});
            dataOut = frame[7:0] & ~(8'hFF << dataBits);
            if (lineControlReg[dasc_pkg::LCR_PAR_EN]) begin
               parErr = frame[dataBits] !=
                  char_parity(dataOut, dataBits, lineControlReg);
            end
            rxBufferReg <= dataOut;
            lineStatusReg[0] <= 1'b1;
            if (lineStatusReg[0]) lineStatusReg[1] <= 1'b1;
            if (parErr) lineStatusReg[2] <= 1'b1;
            if (!rxLine) lineStatusReg[3] <= 1'b1;
            if (!rxLine && frame == 10'h000) lineStatusReg[4] <= 1'b1;
            if (lineStatusReg[0] || parErr || !rxLine) rxLineIrq <= 1'b1;
         end
      end
   end

   // Holding-empty interrupt: set on the empty edge, cleared by write or ident read
   always_ff @(posedge clock) begin
      if (srst) begin
         txEmptyIrq <= 1'b0;
      end else if (!txBusy && !lineStatusReg[dasc_pkg::LSR_TX_HOLD_EMPTY] && baudTick &&
                   !(wrEn && !divAccess && req.addr == dasc_pkg::OFS_DATA)) begin
         txEmptyIrq <= 1'b1;
      end else if (wrEn && !divAccess && req.addr == dasc_pkg::OFS_DATA) begin
         txEmptyIrq <= 1'b0;
      end else if (rdEn && req.addr == dasc_pkg::OFS_IID &&
                   next_iid == dasc_pkg::IID_TXEMPTY) begin
         txEmptyIrq <= 1'b0;
      end
   end

   // Modem deltas: a change in the same cycle as a status read stays set
   always_ff @(posedge clock) begin
      logic [3:0] changed;
      changed = 4'h0;
      if (srst) begin
         modemPrev <= 4'h0;
         deltaFlags <= 4'h0;
      end else begin
         // Ring flag marks the pin falling, i.e. the ring level becoming active
         changed = {modemPrev[3] ^ modemLevel[3], ~modemPrev[2] & modemLevel[2],
                    modemPrev[1:0] ^ modemLevel[1:0]};
         modemPrev <= modemLevel;
         if (rdEn && req.addr == dasc_pkg::OFS_MSR) deltaFlags <= changed;
         else deltaFlags <= deltaFlags | changed;
      end
   end

   // Interrupt priority and read mux
   always_comb begin
      next_iid = dasc_pkg::IID_NONE;
      if (irqEnable[2] && rxLineIrq) next_iid = dasc_pkg::IID_LINE;
      else if (irqEnable[0] && lineStatusReg[0]) next_iid = dasc_pkg::IID_RXDATA;
      else if (irqEnable[1] && txEmptyIrq) next_iid = dasc_pkg::IID_TXEMPTY;
      else if (irqEnable[3] && deltaFlags != 4'h0) next_iid = dasc_pkg::IID_MODEM;
   end

   always_comb begin
      next_read = 8'h00;
      if (req.addr == dasc_pkg::OFS_DATA && divAccess) next_read = divisor[7:0];
      else if (req.addr == dasc_pkg::OFS_IEN && divAccess) next_read = divisor[15:8];
      else if (req.addr == dasc_pkg::OFS_DATA) next_read = rxBufferReg;
      else if (req.addr == dasc_pkg::OFS_IEN) next_read = {4'h0, irqEnable};
      else if (req.addr == dasc_pkg::OFS_IID) next_read = {5'h00, next_iid};
      else if (req.addr == dasc_pkg::OFS_LCR) next_read = lineControlReg;
      else if (req.addr == dasc_pkg::OFS_MCR) next_read = modemControlReg;
      else if (req.addr == dasc_pkg::OFS_LSR) next_read = lineStatusReg;
      else if (req.addr == dasc_pkg::OFS_MSR) begin
         next_read = {modemLevel, deltaFlags};
      end else next_read = scratch;
   end

   assign readData = next_read;
   assign readValid = rdEn;
   assign chanIrqOut = next_iid != dasc_pkg::IID_NONE;
   assign chanIrqOe = modemControlReg[dasc_pkg::MCR_IRQ_EN];
endmodule : dasc_channel

/* dasc_peer.sv */
// Modem model: drives line and handshake inputs, decodes the serial output
`timescale 1ns/10ps
module dasc_peer (
   input wire logic clock,
   input wire logic [1:0] serial_tx_out,
   output logic [1:0] serial_rx_in,
   output logic [1:0] send_clear_n,
   output logic [1:0] set_ready_n,
   output logic [1:0] ring_in_n,
   output logic [1:0] carrier_n
);
   initial begin
      serial_rx_in = 2'b11;
      send_clear_n = 2'b11;
      set_ready_n = 2'b11;
      ring_in_n = 2'b11;
      carrier_n = 2'b11;
   end
   task automatic setModem(input int c, input logic cts, input logic dsr, input logic ri);
      @(negedge clock);
      send_clear_n[c] = cts;
      set_ready_n[c] = dsr;
      ring_in_n[c] = ri;
   endtask : setModem
   // Eight data bits, no parity, one stop; line rests at mark between frames
   task automatic sendChar(input int c, input int bt, input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge clock);
         serial_rx_in[c] = f[i];
         repeat (bt - 1) @(negedge clock);
      end
   endtask : sendChar
   task automatic recvChar(input int c, input int bt, output logic [7:0] d);
      int k;
      k = 0;
      d = 'x;
      // Sample on the falling edge, away from the edge that updates the line
      while (serial_tx_out[c] !== 1'b0 && k < 4000) begin
         @(negedge clock);
         k++;
      end
      repeat (bt / 2) @(negedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (bt) @(negedge clock);
         d[i] = serial_tx_out[c];
      end
   endtask : recvChar
endmodule : dasc_peer

/* dasc_pkg.sv */
// Package: register map, field positions and reset values of the dual serial channel
package dasc_pkg;
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_IEN = 3'h1;
   localparam logic [2:0] OFS_IID = 3'h2;
   localparam logic [2:0] OFS_LCR = 3'h3;
   localparam logic [2:0] OFS_MCR = 3'h4;
   localparam logic [2:0] OFS_LSR = 3'h5;
   localparam logic [2:0] OFS_MSR = 3'h6;
   localparam logic [2:0] OFS_SCR = 3'h7;
   localparam int LCR_DIV_ACCESS = 7;
   localparam int LCR_BREAK = 6;
   localparam int LCR_STICK = 5;
   localparam int LCR_EVEN = 4;
   localparam int LCR_PAR_EN = 3;
   localparam int LCR_STOP2 = 2;
   localparam int MCR_TERM_READY = 0;
   localparam int MCR_SEND_REQ = 1;
   localparam int MCR_IRQ_EN = 3;
   localparam int MCR_LOOP = 4;
   localparam int LSR_TX_HOLD_EMPTY = 5;
   localparam int LSR_TX_ALL_EMPTY = 6;
   localparam logic [7:0] LSR_RESET = 8'h60;
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam logic [15:0] DIV_RESET = 16'h0001;
   localparam logic [2:0] IID_NONE = 3'h1;
   localparam logic [2:0] IID_LINE = 3'h6;
   localparam logic [2:0] IID_RXDATA = 3'h4;
   localparam logic [2:0] IID_TXEMPTY = 3'h2;
   localparam logic [2:0] IID_MODEM = 3'h0;
   localparam logic [3:0] OVERSAMPLE = 4'hF;
   localparam logic [3:0] MID_SAMPLE = 4'h7;

   typedef struct packed {
      logic sendClearN;
      logic setReadyN;
      logic ringInN;
      logic carrierN;
   } dasc_modem_in_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] addr;
      logic [7:0] data;
   } dasc_host_req_t;
endpackage : dasc_pkg

/* dasc_sync.sv */
// Three-stage synchroniser with agreement filter for a bundle of pin inputs
`timescale 1ns/10ps
module dasc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] stable
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Elaboration-time refusal of an empty bundle
   if (WIDTH < 1) begin : g_width_check
      $error("dasc_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
      end else begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // A change counts only once the last two stages agree
   always_ff @(posedge clock) begin
      if (srst) begin
         stable <= INIT;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               stable[i] <= stage3[i];
            end
         end
      end
   end
endmodule : dasc_sync

/* dasc_top.sv */
// Top: two independent serial channels sharing the host bus, clock and reset
`timescale 1ns/10ps
module dasc_top (
   input wire logic clock,
   input wire logic srst,
   input wire logic host_write_n,
   input wire logic host_read_n,
   input wire logic [2:0] host_addr,
   input wire logic chan0_select_n,
   input wire logic chan1_select_n,
   input wire logic [7:0] host_data_bus_in,
   output logic [7:0] host_data_bus_out,
   output logic host_data_bus_oe,
   input wire logic [1:0] serial_rx_in,
   input wire logic [1:0] send_clear_n,
   input wire logic [1:0] set_ready_n,
   input wire logic [1:0] ring_in_n,
   input wire logic [1:0] carrier_n,
   output logic [1:0] serial_tx_out,
   output logic [1:0] terminal_ready_n,
   output logic [1:0] send_request_n,
   output logic [1:0] chan_irq_out,
   output logic [1:0] chan_irq_oe
);
   logic [24:0] pinsSync;
   logic wrN;
   logic rdN;
   logic wrPrev;
   logic rdPrev;
   logic [1:0] selN;
   dasc_pkg::dasc_host_req_t req;
   logic [7:0] chData [2];
   logic [1:0] chValid;
   logic [1:0] txOut;
   logic [1:0] dtrN;
   logic [1:0] rtsN;
   logic [1:0] irqOut;
   logic [1:0] irqOe;

   // Data is filtered too; the host holds it past the strobe, so it settles first
   dasc_sync #(.WIDTH(25), .INIT(25'h1FF_FFFF)) u_sync (
      .clock(clock),
      .srst(srst),
      .pinIn({host_write_n, host_read_n, chan0_select_n, chan1_select_n,
              serial_rx_in, send_clear_n, set_ready_n, ring_in_n, carrier_n,
              host_addr, host_data_bus_in}),
      .stable(pinsSync)
   );

   assign wrN = pinsSync[24];
   assign rdN = pinsSync[23];
   assign selN = {pinsSync[21], pinsSync[22]};

   // Write and read each act once per strobe, on the strobe's rising edge
   always_ff @(posedge clock) begin
      if (srst) begin
         wrPrev <= 1'b1;
         rdPrev <= 1'b1;
         req <= '0;
      end else begin
         wrPrev <= wrN;
         rdPrev <= rdN;
         req.wr <= !wrPrev && wrN;
         req.rd <= !rdPrev && rdN;
         req.addr <= pinsSync[10:8];
         req.data <= pinsSync[7:0];
      end
   end

   for (genvar c = 0; c < 2; c++) begin : g_chan
      dasc_channel u_chan (
         .clock(clock),
         .srst(srst),
         .sel(!selN[c] && selN[1-c]),
         .req(req),
         .readData(chData[c]),
         .readValid(chValid[c]),
         .serialRxIn(pinsSync[19 + c]),
         .modemIn({pinsSync[17 + c], pinsSync[15 + c], pinsSync[13 + c], pinsSync[11 + c]}),
         .serialTxOut(txOut[c]),
         .terminalReadyN(dtrN[c]),
         .sendRequestN(rtsN[c]),
         .chanIrqOut(irqOut[c]),
         .chanIrqOe(irqOe[c])
      );
   end

   // Bus drive follows the live read strobe; read side effects occur at strobe end
   always_ff @(posedge clock) begin
      if (srst) begin
         host_data_bus_out <= 8'h00;
         host_data_bus_oe <= 1'b0;
      end else begin
         host_data_bus_oe <= !rdN && (selN != 2'b11) && (selN != 2'b00);
         host_data_bus_out <= !selN[0] ? chData[0] : chData[1];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         serial_tx_out <= 2'b11;
         terminal_ready_n <= 2'b11;
         send_request_n <= 2'b11;
         chan_irq_out <= 2'b00;
         chan_irq_oe <= 2'b00;
      end else begin
         serial_tx_out <= txOut;
         terminal_ready_n <= dtrN;
         send_request_n <= rtsN;
         chan_irq_out <= irqOut;
         chan_irq_oe <= irqOe;
      end
   end
endmodule : dasc_top

/* dasc_top_properties.sv */
// Checker: port-level timing relations of the dual serial channel
`timescale 1ns/10ps
module dasc_top_checker (
   input wire logic clock,
   input wire logic srst,
   input wire logic host_write_n,
   input wire logic host_read_n,
   input wire logic chan0_select_n,
   input wire logic chan1_select_n,
   input wire logic host_data_bus_oe,
   input wire logic [1:0] serial_tx_out,
   input wire logic [1:0] terminal_ready_n,
   input wire logic [1:0] send_request_n,
   input wire logic [1:0] chan_irq_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   logic wrPrev;
   logic anyWr;
   logic [3:0] rdAge;
   logic [3:0] age0;
   logic [3:0] age1;
   always_ff @(posedge clock) wrPrev <= host_write_n;
   always_ff @(posedge clock) begin
      if (srst) anyWr <= 1'b0;
      else if (!host_write_n) anyWr <= 1'b1;
   end
   // Ages saturate so a long quiet spell cannot wrap into a false cause
   always_ff @(posedge clock) begin
      if (srst || !host_read_n) rdAge <= 4'h0;
      else if (rdAge != 4'hF) rdAge <= rdAge + 4'h1;
   end
   always_ff @(posedge clock) begin
      if (srst) age0 <= 4'hF;
      else if (host_write_n && !wrPrev && !chan0_select_n && chan1_select_n) age0 <= 4'h0;
      else if (age0 != 4'hF) age0 <= age0 + 4'h1;
   end
   always_ff @(posedge clock) begin
      if (srst) age1 <= 4'hF;
      else if (host_write_n && !wrPrev && chan0_select_n && !chan1_select_n) age1 <= 4'h0;
      else if (age1 != 4'hF) age1 <= age1 + 4'h1;
   end
   a_reset_idle: assert property ($fell(srst) |-> serial_tx_out == 2'b11 &&
      terminal_ready_n == 2'b11 && send_request_n == 2'b11 && chan_irq_oe == 2'b00)
      else $error("outputs not idle after reset");
   a_idle_mark: assert property (!anyWr |-> serial_tx_out == 2'b11)
      else $error("serial output left mark with nothing written");
   a_bus_quiet: assert property (host_read_n [*8] |-> !host_data_bus_oe)
      else $error("data bus driven without a read");
   a_dual_select: assert property (
      (!chan0_select_n && !chan1_select_n) [*8] |-> !host_data_bus_oe)
      else $error("data bus driven with both channels selected");
   a_oe_cause: assert property ($rose(host_data_bus_oe) |-> rdAge <= 4'd8)
      else $error("data bus enabled long after any read strobe");
   a_chan0_cause: assert property (
      ($changed(terminal_ready_n[0]) || $changed(send_request_n[0]) ||
      $changed(chan_irq_oe[0])) |-> age0 <= 4'd10)
      else $error("channel 0 modem output moved without its write");
   a_chan1_cause: assert property (
      ($changed(terminal_ready_n[1]) || $changed(send_request_n[1]) ||
      $changed(chan_irq_oe[1])) |-> age1 <= 4'd10)
      else $error("channel 1 modem output moved without its write");
   a_bit_width: assert property ($fell(serial_tx_out[0]) |=> !serial_tx_out[0] [*8])
      else $error("serial bit shorter than the minimum divisor allows");
endmodule : dasc_top_checker

bind dasc_top dasc_top_checker u_chk (.clock, .srst, .host_write_n, .host_read_n,
   .chan0_select_n, .chan1_select_n, .host_data_bus_oe, .serial_tx_out,
   .terminal_ready_n, .send_request_n, .chan_irq_oe);

/* dasc_top_tb.sv */
// Testbench: host-side scenarios for the dual serial channel
`timescale 1ns/10ps
module dasc_top_tb;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic host_write_n = 1'b1;
   logic host_read_n = 1'b1;
   logic [2:0] host_addr = 3'h0;
   logic chan0_select_n = 1'b1;
   logic chan1_select_n = 1'b1;
   logic [7:0] host_data_bus_in = 8'h00;
   logic [7:0] host_data_bus_out;
   logic host_data_bus_oe;
   logic [1:0] serial_rx_in, send_clear_n, set_ready_n, ring_in_n, carrier_n;
   logic [1:0] serial_tx_out, terminal_ready_n, send_request_n, chan_irq_out, chan_irq_oe;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [7:0] rd;
   always #4 clock = ~clock;
   dasc_top u_dut (.clock, .srst, .host_write_n, .host_read_n, .host_addr, .chan0_select_n,
      .chan1_select_n, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe,
      .serial_rx_in, .send_clear_n, .set_ready_n, .ring_in_n, .carrier_n, .serial_tx_out,
      .terminal_ready_n, .send_request_n, .chan_irq_out, .chan_irq_oe);
   dasc_peer u_peer (.clock, .serial_tx_out, .serial_rx_in, .send_clear_n, .set_ready_n,
      .ring_in_n, .carrier_n);
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask : chk
   // 2 selects both channels on purpose, 3 deselects
   task automatic selp(input int c);
      {chan1_select_n, chan0_select_n} = (c == 0) ? 2'b10 : (c == 1) ? 2'b01 :
         (c == 2) ? 2'b00 : 2'b11;
   endtask : selp
   // Strobes held 8 cycles each way, well past the input filter settle time
   task automatic hw(input int c, input logic [2:0] a, input logic [7:0] d);
      @(negedge clock);
      selp(c);
      host_addr = a;
      host_data_bus_in = d;
      host_write_n = 1'b0;
      repeat (8) @(negedge clock);
      host_write_n = 1'b1;
      repeat (8) @(negedge clock);
      selp(3);
   endtask : hw
   task automatic hr(input int c, input logic [2:0] a, output logic [7:0] d);
      @(negedge clock);
      selp(c);
      host_addr = a;
      host_read_n = 1'b0;
      repeat (8) @(negedge clock);
      d = (host_data_bus_oe === 1'b1) ? host_data_bus_out : 8'hxx;
      host_read_n = 1'b1;
      repeat (8) @(negedge clock);
      selp(3);
   endtask : hr
   task automatic t_reset();
      chk("tx_out", 8'h03, {6'h00, serial_tx_out});
      chk("dtr", 8'h03, {6'h00, terminal_ready_n});
      chk("rts", 8'h03, {6'h00, send_request_n});
      chk("irq_oe", 8'h00, {6'h00, chan_irq_oe});
      chk("bus_oe", 8'h00, {7'h00, host_data_bus_oe});
      hr(0, dasc_pkg::OFS_LSR, rd);
      chk("lsr", 8'h60, rd);
      hr(1, dasc_pkg::OFS_MCR, rd);
      chk("mcr1", 8'h00, rd);
      $display("test reset done");
   endtask : t_reset
   task automatic t_mcr();
      hw(0, dasc_pkg::OFS_MCR, 8'h03);
      chk("dtr on", 8'h02, {6'h00, terminal_ready_n});
      chk("rts on", 8'h02, {6'h00, send_request_n});
      hw(2, dasc_pkg::OFS_MCR, 8'h03);
      chk("dtr dual", 8'h02, {6'h00, terminal_ready_n});
      hw(0, dasc_pkg::OFS_MCR, 8'h00);
      chk("dtr off", 8'h03, {6'h00, terminal_ready_n});
      $display("test modem control done");
   endtask : t_mcr
   task automatic t_modem();
      hw(0, dasc_pkg::OFS_IEN, 8'h08);
      hw(0, dasc_pkg::OFS_MCR, 8'h08);
      chk("irq_oe on", 8'h01, {6'h00, chan_irq_oe});
      hr(0, dasc_pkg::OFS_MSR, rd);
      u_peer.setModem(0, 1'b0, 1'b0, 1'b1);
      repeat (20) @(negedge clock);
      chk("irq set", 8'h01, {6'h00, chan_irq_out});
      hr(0, dasc_pkg::OFS_MSR, rd);
      chk("msr", 8'h33, rd);
      chk("irq clr", 8'h00, {6'h00, chan_irq_out});
      u_peer.setModem(0, 1'b0, 1'b0, 1'b0);
      repeat (20) @(negedge clock);
      hr(0, dasc_pkg::OFS_MSR, rd);
      chk("msr ring", 8'h74, rd);
      $display("test modem status done");
   endtask : t_modem
   task automatic t_txrx();
      hw(0, dasc_pkg::OFS_LCR, 8'h83);
      hw(0, dasc_pkg::OFS_DATA, 8'h02);
      hr(0, dasc_pkg::OFS_DATA, rd);
      chk("div lo", 8'h02, rd);
      hw(0, dasc_pkg::OFS_DATA, 8'h01);
      hw(0, dasc_pkg::OFS_LCR, 8'h03);
      hr(0, dasc_pkg::OFS_LCR, rd);
      chk("lcr", 8'h03, rd);
      fork
         hw(0, dasc_pkg::OFS_DATA, 8'hA5);
         u_peer.recvChar(0, 16, rd);
      join
      chk("tx char", 8'hA5, rd);
      hw(1, dasc_pkg::OFS_LCR, 8'h03);
      u_peer.sendChar(1, 16, 8'h3C);
      repeat (8) @(negedge clock);
      hr(1, dasc_pkg::OFS_DATA, rd);
      chk("rx char", 8'h3C, rd);
      $display("test serial done");
   endtask : t_txrx
   initial begin
      repeat (16) @(negedge clock);
      srst = 1'b0;
      repeat (6) @(negedge clock);
      t_reset();
      t_mcr();
      t_modem();
      t_txrx();
      results();
   end
endmodule : dasc_top_tb
